// ### pkg/rtsh_regs.svh
// Offsets, fields and timing figures of the ramp time select and hold block.
// Assumes a 12-bit AXI4-Lite byte address space, one register per aligned word.
`ifndef RTSH_REGS_SVH
`define RTSH_REGS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define RTSH_CTRL_OFS      12'h000
`define RTSH_BASE_ACC_OFS  12'h004
`define RTSH_BASE_DEC_OFS  12'h008
`define RTSH_ACC_PF_OFS    12'h00C
`define RTSH_ACC_PT_OFS    12'h010
`define RTSH_DEC_PF_OFS    12'h014
`define RTSH_DEC_PT_OFS    12'h018
`define RTSH_STATUS_OFS    12'h01C
`define RTSH_FUNC_BASE     12'h040
`define RTSH_FREQ_BASE     12'h100
`define RTSH_ACC_BASE      12'h200
`define RTSH_DEC_BASE      12'h300
`define RTSH_ARRAY_MASK    12'hFC0
// ==========================================================
// Fields and codes
`define RTSH_TIME_W        20
`define RTSH_FREQ_W        16
`define RTSH_STAGED_PER_SPD 2'h1
`define RTSH_FUNC_SPD0     8'h03
`define RTSH_FUNC_HOLD     8'h64
`define RTSH_RESP_OKAY     2'h0
`define RTSH_RESP_SLVERR   2'h2
// ==========================================================
// Timing: hold time resolution and clock period
`define RTSH_HOLD_RES_NS   10000000
`define RTSH_CLK_PERIOD_NS 50
`define RTSH_TICK_CYC      (`RTSH_HOLD_RES_NS / `RTSH_CLK_PERIOD_NS)
`endif

// ### pkg/rtsh_pkg.sv
// Types shared by the ramp time select and hold block.
// Assumes rtsh_regs.svh is on the include path.
`default_nettype none
`include "rtsh_regs.svh"
package rtsh_pkg;
	// ==========================================================
	// Hold state machine
	typedef enum logic [0:0] {
		RTSH_HS_RUN  = 1'b0,
		RTSH_HS_HOLD = 1'b1
	} rtsh_hold_e;
	// ==========================================================
	// Result handed to the ramp generator
	typedef struct packed {
		logic [`RTSH_FREQ_W-1:0] target;
		logic [`RTSH_TIME_W-1:0] acc_time;
		logic [`RTSH_TIME_W-1:0] dec_time;
		logic                    freeze;
	} rtsh_ramp_s;
endpackage
`default_nettype wire

// ### core/rtsh_core.sv
// Ramp time selection per multi-speed step and ramp hold (automatic and terminal).
// Assumes terminals and ramp status are synchronous to mclk_i; frequencies in 0.01 Hz,
// ramp times in 0.01 s, hold times in 0.01 s.
// How it works
// - Rising step uses that speed's acceleration time
// - Falling step uses left speed's deceleration time
// - Deceleration time switches before target updates
// - Hold ignores the selected ramp shapes
// - Automatic and terminal hold combine by OR
// - Accel hold at set frequency for set time
// - Decel hold at set frequency for set time
// - Zero hold frequency disables automatic hold
// - Hold-function terminal freezes ramp while active
// - Per-speed times only when staged select 01
// - Four select inputs form binary speed index
`timescale 1ns/1ps
`default_nettype none
`include "rtsh_regs.svh"
module rtsh_core
	import rtsh_pkg::*;
#(
	parameter int unsigned TICK_CYC = `RTSH_TICK_CYC,
	parameter int unsigned N_TERM   = 11
)(
	// Clock and reset
	input  wire logic                    mclk_i,
	input  wire logic                    rstn_i,
	// AXI4-Lite slave
	input  wire logic [11:0]             s_axi_awaddr_i,
	input  wire logic                    s_axi_awvalid_i,
	output logic                         s_axi_awready_o,
	input  wire logic [31:0]             s_axi_wdata_i,
	input  wire logic [3:0]              s_axi_wstrb_i,
	input  wire logic                    s_axi_wvalid_i,
	output logic                         s_axi_wready_o,
	output logic [1:0]                   s_axi_bresp_o,
	output logic                         s_axi_bvalid_o,
	input  wire logic                    s_axi_bready_i,
	input  wire logic [11:0]             s_axi_araddr_i,
	input  wire logic                    s_axi_arvalid_i,
	output logic                         s_axi_arready_o,
	output logic [31:0]                  s_axi_rdata_o,
	output logic [1:0]                   s_axi_rresp_o,
	output logic                         s_axi_rvalid_o,
	input  wire logic                    s_axi_rready_i,
	// Input terminals and ramp status
	input  wire logic [N_TERM-1:0]       term_i,
	input  wire logic [`RTSH_FREQ_W-1:0] out_freq_i,
	input  wire logic                    accel_i,
	input  wire logic                    decel_i,
	// To the ramp generator
	output var  rtsh_ramp_s              ramp_o
);
	localparam int TW = `RTSH_TIME_W;
	localparam int FW = `RTSH_FREQ_W;
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

	// ==========================================================
	// Configuration storage
	logic [5:0]    ctrl_q;
	logic [TW-1:0] base_acc_q, base_dec_q;
	logic [FW-1:0] acc_pf_q, acc_pt_q, dec_pf_q, dec_pt_q;
	logic [7:0]    func_q  [N_TERM];
	logic [FW-1:0] spd_f_q [16];
	logic [TW-1:0] spd_a_q [16];
	logic [TW-1:0] spd_d_q [16];

	// Speed, selection and hold state
	logic [3:0]    spd_q, acc_sel_q, dec_sel_q;
	logic          chg_q;
	logic [FW-1:0] prev_freq_q;
	rtsh_hold_e    hold_st_q;
	logic          hold_dec_q;
	logic [31:0]   pre_q;
	logic [FW-1:0] cnt_q;
	rtsh_ramp_s    ramp_q;

	// AXI state
	logic          aw_got_q, w_got_q, bvalid_q, rvalid_q;
	logic [11:0]   awaddr_q;
	logic [31:0]   wdata_q, rdata_q;
	logic [3:0]    wstrb_q;
	logic [1:0]    bresp_q, rresp_q;

	// ==========================================================
	// Functions
	function automatic logic [N_TERM-1:0] term_match(input logic [7:0] code);
		for (int i = 0; i < N_TERM; i++)
			term_match[i] = (func_q[i] == code);
	endfunction

	function automatic logic in_array(input logic [11:0] a, input logic [11:0] base);
		in_array = ((a & `RTSH_ARRAY_MASK) == base);
	endfunction

	function automatic logic map_ok(input logic [11:0] a);
		map_ok = (a[11:5] == 7'h00) || in_array(a, `RTSH_FREQ_BASE)
			|| in_array(a, `RTSH_ACC_BASE) || in_array(a, `RTSH_DEC_BASE)
			|| (in_array(a, `RTSH_FUNC_BASE) && (32'(a[5:2]) < N_TERM));
	endfunction

	function automatic logic [31:0] rd_word(input logic [11:0] a);
		rd_word = 32'h0;
		case (a)
			`RTSH_CTRL_OFS:     rd_word = {26'h0, ctrl_q};
			`RTSH_BASE_ACC_OFS: rd_word = 32'(base_acc_q);
			`RTSH_BASE_DEC_OFS: rd_word = 32'(base_dec_q);
			`RTSH_ACC_PF_OFS:   rd_word = 32'(acc_pf_q);
			`RTSH_ACC_PT_OFS:   rd_word = 32'(acc_pt_q);
			`RTSH_DEC_PF_OFS:   rd_word = 32'(dec_pf_q);
			`RTSH_DEC_PT_OFS:   rd_word = 32'(dec_pt_q);
			`RTSH_STATUS_OFS:   rd_word = {8'h0, spd_q, ramp_q.freeze, hold_dec_q,
				hold_st_q == RTSH_HS_HOLD, 1'b0, cnt_q};
			default:
			begin
				if (in_array(a, `RTSH_FREQ_BASE))
					rd_word = 32'(spd_f_q[a[5:2]]);
				else if (in_array(a, `RTSH_ACC_BASE))
					rd_word = 32'(spd_a_q[a[5:2]]);
				else if (in_array(a, `RTSH_DEC_BASE))
					rd_word = 32'(spd_d_q[a[5:2]]);
				else if (in_array(a, `RTSH_FUNC_BASE) && (32'(a[5:2]) < N_TERM))
					rd_word = {24'h0, func_q[a[5:2]]};
			end
		endcase
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int b = 0; b < 4; b++)
			wmerge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
	endfunction

	// ==========================================================
	// AXI4-Lite slave, one write and one read at a time
	wire         aw_hs  = s_axi_awvalid_i && !aw_got_q;
	wire         w_hs   = s_axi_wvalid_i && !w_got_q;
	wire         wr_go  = aw_got_q && w_got_q && !bvalid_q;
	wire         ar_hs  = s_axi_arvalid_i && !rvalid_q;
	wire         wr_ok  = map_ok(awaddr_q);
	wire [31:0]  wr_val = wmerge(rd_word(awaddr_q), wdata_q, wstrb_q);
	wire [3:0]   wr_idx = awaddr_q[5:2];

	assign s_axi_awready_o = !aw_got_q;
	assign s_axi_wready_o  = !w_got_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;
	assign s_axi_arready_o = !rvalid_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= 12'h0;
			wdata_q  <= 32'h0;
			wstrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= `RTSH_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= `RTSH_RESP_OKAY;
		end
		else
		begin
			if (aw_hs)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_i;
			end
			if (w_hs)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			if (wr_go)
			begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? `RTSH_RESP_OKAY : `RTSH_RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready_i)
				bvalid_q <= 1'b0;
			if (ar_hs)
			begin
				rvalid_q <= 1'b1;
				rdata_q  <= map_ok(s_axi_araddr_i) ? rd_word(s_axi_araddr_i) : 32'h0;
				rresp_q  <= map_ok(s_axi_araddr_i) ? `RTSH_RESP_OKAY : `RTSH_RESP_SLVERR;
			end
			else if (rvalid_q && s_axi_rready_i)
				rvalid_q <= 1'b0;
		end
	end

	// Shape fields (bits 5:2) are stored only; hold never looks at them
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ctrl_q     <= 6'h0;
			base_acc_q <= '0;
			base_dec_q <= '0;
			acc_pf_q   <= '0;
			acc_pt_q   <= '0;
			dec_pf_q   <= '0;
			dec_pt_q   <= '0;
			for (int i = 0; i < N_TERM; i++)
				func_q[i] <= 8'h0;
			for (int i = 0; i < 16; i++)
			begin
				spd_f_q[i] <= '0;
				spd_a_q[i] <= '0;
				spd_d_q[i] <= '0;
			end
		end
		else if (wr_go && wr_ok)
		begin
			case (awaddr_q)
				`RTSH_CTRL_OFS:     ctrl_q     <= wr_val[5:0];
				`RTSH_BASE_ACC_OFS: base_acc_q <= wr_val[TW-1:0];
				`RTSH_BASE_DEC_OFS: base_dec_q <= wr_val[TW-1:0];
				`RTSH_ACC_PF_OFS:   acc_pf_q   <= wr_val[FW-1:0];
				`RTSH_ACC_PT_OFS:   acc_pt_q   <= wr_val[FW-1:0];
				`RTSH_DEC_PF_OFS:   dec_pf_q   <= wr_val[FW-1:0];
				`RTSH_DEC_PT_OFS:   dec_pt_q   <= wr_val[FW-1:0];
				default:
				begin
					if (in_array(awaddr_q, `RTSH_FREQ_BASE))
						spd_f_q[wr_idx] <= wr_val[FW-1:0];
					else if (in_array(awaddr_q, `RTSH_ACC_BASE))
						spd_a_q[wr_idx] <= wr_val[TW-1:0];
					else if (in_array(awaddr_q, `RTSH_DEC_BASE))
						spd_d_q[wr_idx] <= wr_val[TW-1:0];
					else if (in_array(awaddr_q, `RTSH_FUNC_BASE))
						func_q[wr_idx] <= wr_val[7:0];
				end
			endcase
		end
	end

	// ==========================================================
	// Terminal decode and ramp time selection
	wire [3:0] spd_idx = {|(term_i & term_match(`RTSH_FUNC_SPD0 + 8'h3)),
		|(term_i & term_match(`RTSH_FUNC_SPD0 + 8'h2)),
		|(term_i & term_match(`RTSH_FUNC_SPD0 + 8'h1)),
		|(term_i & term_match(`RTSH_FUNC_SPD0))};
	wire       term_hold = |(term_i & term_match(`RTSH_FUNC_HOLD));
	wire       chg       = (spd_idx != spd_q);
	wire       per_spd   = (ctrl_q[1:0] == `RTSH_STAGED_PER_SPD);
	wire       spd_up    = (spd_idx != 4'h0) && (spd_f_q[spd_idx] > spd_f_q[spd_q]);
	wire       spd_down  = (spd_q != 4'h0) && (spd_f_q[spd_q] > spd_f_q[spd_idx]);

	// ==========================================================
	// Automatic hold detection: crossing of the hold frequency while ramping
	wire acc_hit = accel_i && (acc_pf_q != '0)
		&& (prev_freq_q < acc_pf_q) && (out_freq_i >= acc_pf_q);
	wire dec_hit = decel_i && (dec_pf_q != '0)
		&& (prev_freq_q > dec_pf_q) && (out_freq_i <= dec_pf_q);
	wire hold_time_up = (cnt_q >= (hold_dec_q ? dec_pt_q : acc_pt_q));
	wire tick = (pre_q == TICK_LAST);

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			spd_q       <= 4'h0;
			acc_sel_q   <= 4'h0;
			dec_sel_q   <= 4'h0;
			chg_q       <= 1'b0;
			prev_freq_q <= '0;
			hold_st_q   <= RTSH_HS_RUN;
			hold_dec_q  <= 1'b0;
			pre_q       <= 32'h0;
			cnt_q       <= '0;
			ramp_q      <= '0;
		end
		else
		begin
			chg_q       <= chg;
			prev_freq_q <= out_freq_i;
			if (chg)
			begin
				spd_q     <= spd_idx;
				acc_sel_q <= spd_up ? spd_idx : 4'h0;
				dec_sel_q <= spd_down ? spd_q : 4'h0;
			end
			// Target waits two edges so the new decel time is already out
			if (!chg && !chg_q)
				ramp_q.target <= spd_f_q[spd_q];
			ramp_q.acc_time <= (per_spd && acc_sel_q != 4'h0) ? spd_a_q[acc_sel_q] : base_acc_q;
			ramp_q.dec_time <= (per_spd && dec_sel_q != 4'h0) ? spd_d_q[dec_sel_q] : base_dec_q;
			case (hold_st_q)
				RTSH_HS_RUN:
				begin
					pre_q <= 32'h0;
					cnt_q <= '0;
					if (acc_hit || dec_hit)
					begin
						hold_st_q  <= RTSH_HS_HOLD;
						hold_dec_q <= dec_hit && !acc_hit;
					end
				end
				RTSH_HS_HOLD:
				begin
					// 10 ms prescaler feeding the hold counter
					pre_q <= tick ? 32'h0 : pre_q + 32'h1;
					if (tick)
						cnt_q <= cnt_q + 1'b1;
					// Aborted ramp also ends the hold, else it would outlive the ramp
					if (hold_time_up || !(accel_i || decel_i))
						hold_st_q <= RTSH_HS_RUN;
				end
				default: hold_st_q <= RTSH_HS_RUN;
			endcase
			ramp_q.freeze <= (hold_st_q == RTSH_HS_HOLD && !hold_time_up)
				|| (term_hold && (accel_i || decel_i));
		end
	end

	assign ramp_o = ramp_q;

	// ==========================================================
	// Assertions
	a_acc_hold_start: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(hold_st_q == RTSH_HS_RUN && acc_hit && acc_pt_q != '0)
		|=> (hold_st_q == RTSH_HS_HOLD) ##1 ramp_q.freeze)
		else $error("accel hold did not start");
	a_dec_hold_start: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(hold_st_q == RTSH_HS_RUN && dec_hit && !acc_hit) |=> hold_dec_q)
		else $error("decel hold not recorded");
	a_zero_freq_idle: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(hold_st_q == RTSH_HS_RUN && acc_pf_q == '0 && dec_pf_q == '0)
		|=> (hold_st_q == RTSH_HS_RUN))
		else $error("hold at zero frequency");
	a_term_freeze: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(term_hold && accel_i) |=> ramp_q.freeze)
		else $error("terminal hold ignored");
	a_hold_or_both: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(ramp_q.freeze && !$past(term_hold)) |-> $past(hold_st_q == RTSH_HS_HOLD))
		else $error("freeze without cause");
	a_hold_release: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(hold_st_q == RTSH_HS_HOLD && hold_time_up) |=> (hold_st_q == RTSH_HS_RUN))
		else $error("hold outlived its time");
	a_dec_before_tgt: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		chg |=> $stable(ramp_q.target) ##1 $stable(ramp_q.target))
		else $error("target moved with the time switch");
	a_base_times: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!per_spd |=> (ramp_q.acc_time == $past(base_acc_q)) && (ramp_q.dec_time == $past(base_dec_q)))
		else $error("per-speed time outside mode 01");
	a_speed_decode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		chg |=> (spd_q == $past(spd_idx)))
		else $error("speed index not taken");
	a_up_select: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(chg && spd_up) |=> (acc_sel_q == $past(spd_idx)) && (dec_sel_q == 4'h0))
		else $error("wrong accel selection");
	c_acc_hold: cover property (@(posedge mclk_i) disable iff (!rstn_i)
		hold_st_q == RTSH_HS_HOLD && !hold_dec_q ##1 hold_st_q == RTSH_HS_RUN);
	c_dec_step: cover property (@(posedge mclk_i) disable iff (!rstn_i)
		chg && spd_down && per_spd);
	c_both_holds: cover property (@(posedge mclk_i) disable iff (!rstn_i)
		hold_st_q == RTSH_HS_HOLD && term_hold);
endmodule
`default_nettype wire

// ### verif/rtsh_term_model.sv
// Terminal side model: speed select bits and the hold terminal.
// Assumes function codes 0x03..0x06 sit on terminals 0..3 and 0x64 on terminal 4.
`timescale 1ns/1ps
`default_nettype none
module rtsh_term_model
	import rtsh_pkg::*;
(
	// Commands from the bench
	input  wire logic [3:0]  spd_i,
	input  wire logic        hold_i,
	// Terminal levels
	output logic      [10:0] term_o
);
	// ==========================================================
	// Terminal map
	// Unassigned terminals stay low: any level is legal there
	assign term_o = {6'h00, hold_i, spd_i};
endmodule
`default_nettype wire

// ### verif/test_ramp_time_select_and_hold.sv
// Self-checking bench: AXI4-Lite set-up, speed step ramp times, hold behaviour.
// Assumes rtsh_regs.svh on the include path and TICK_CYC shortened to 4.
`timescale 1ns/1ps
`default_nettype none
`include "rtsh_regs.svh"
module test_ramp_time_select_and_hold
	import rtsh_pkg::*;
;
	localparam int T = 4;
	logic        mclk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata_o, rd;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp;
	logic [10:0] term;
	logic [15:0] out_freq = 16'h0;
	logic        accel = 1'b0, decel = 1'b0, hold = 1'b0;
	logic [3:0]  spd = 4'h0;
	rtsh_ramp_s  ramp;
	int          n_fail = 0, n_tests = 0, cnt;
	always #25 mclk_i = ~mclk_i;
	rtsh_term_model u_rtsh_term_model (.spd_i(spd), .hold_i(hold), .term_o(term));
	rtsh_core #(.TICK_CYC(T)) u_rtsh_core (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata_o), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .term_i(term),
		.out_freq_i(out_freq), .accel_i(accel), .decel_i(decel), .ramp_o(ramp));
	// ==========================================================
	// Report
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ==========================================================
	// AXI4-Lite master; handshakes sampled just before the taking edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw, pb, ra, rw, rb;
		int   n;
		@(posedge mclk_i);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		pa = 1'b1; pw = 1'b1; pb = 1'b1;
		for (n = 0; n < 50 && pb; n++)
		begin
			@(negedge mclk_i);
			ra = awready; rw = wready; rb = bvalid; rsp = bresp;
			@(posedge mclk_i);
			if (pa && ra === 1'b1) begin awvalid <= 1'b0; pa = 1'b0; end
			if (pw && rw === 1'b1) begin wvalid <= 1'b0; pw = 1'b0; end
			if (!pa && !pw && rb === 1'b1) begin bready <= 1'b0; pb = 1'b0; end
		end
		if (pb) begin n_fail++; wrap_up(); end
		chk(32'(rsp), 32'(er));
	endtask
	task automatic rdx(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic pa, pr, ra, rv;
		int   n;
		@(posedge mclk_i);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		pa = 1'b1; pr = 1'b1;
		for (n = 0; n < 50 && pr; n++)
		begin
			@(negedge mclk_i);
			ra = arready; rv = rvalid; rd = rdata_o; rsp = rresp;
			@(posedge mclk_i);
			if (pa && ra === 1'b1) begin arvalid <= 1'b0; pa = 1'b0; end
			if (!pa && rv === 1'b1) begin rready <= 1'b0; pr = 1'b0; end
		end
		if (pr) begin n_fail++; wrap_up(); end
		chk(rd, ed);
		chk(32'(rsp), 32'(er));
	endtask
	// Step the speed and check time before target
	task automatic step(input logic [3:0] s, input logic [19:0] ea, input logic [19:0] ed,
			input logic [15:0] old_t);
		@(posedge mclk_i);
		spd <= s;
		repeat (2) @(posedge mclk_i);
		#1;
		chk(32'(ramp.acc_time), 32'(ea));
		chk(32'(ramp.dec_time), 32'(ed));
		chk(32'(ramp.target), 32'(old_t));
		@(posedge mclk_i);
		#1;
		chk(32'(ramp.target), 32'(16'(s) * 16'd100));
	endtask
	// Cross a hold frequency, count frozen cycles
	task automatic pause(input logic dn, input logic [15:0] f0, input logic [15:0] f1);
		@(posedge mclk_i);
		accel <= !dn; decel <= dn; out_freq <= f0;
		@(posedge mclk_i);
		out_freq <= f1;
		cnt = 0;
		repeat (40)
		begin
			@(posedge mclk_i);
			#1;
			if (ramp.freeze === 1'b1) cnt++;
		end
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		#2000000;
		n_fail++;
		wrap_up();
	end
	initial
	begin
		repeat (6) @(posedge mclk_i);
		rstn_i <= 1'b1;
		#1;
		chk(32'(ramp.target), 32'h0);
		chk(32'(ramp.acc_time), 32'h0);
		chk(32'(ramp.dec_time), 32'h0);
		chk(32'(ramp.freeze), 32'h0);
		rdx(`RTSH_STATUS_OFS, 32'h0, `RTSH_RESP_OKAY);
		rdx(`RTSH_CTRL_OFS, 32'h0, `RTSH_RESP_OKAY);
		rdx(12'h800, 32'h0, `RTSH_RESP_SLVERR);
		wr(12'h800, 32'h1, `RTSH_RESP_SLVERR);
		wr(`RTSH_STATUS_OFS, 32'hFFFFFFFF, `RTSH_RESP_OKAY);
		rdx(`RTSH_STATUS_OFS, 32'h0, `RTSH_RESP_OKAY);
		// Shapes set to non-linear: hold must not care
		wr(`RTSH_CTRL_OFS, 32'h3D, `RTSH_RESP_OKAY);
		rdx(`RTSH_CTRL_OFS, 32'h3D, `RTSH_RESP_OKAY);
		wr(`RTSH_BASE_ACC_OFS, 32'h111, `RTSH_RESP_OKAY);
		wr(`RTSH_BASE_DEC_OFS, 32'h222, `RTSH_RESP_OKAY);
		for (int i = 0; i < 4; i++)
			wr(`RTSH_FUNC_BASE + 12'(4 * i), 32'(`RTSH_FUNC_SPD0 + i), `RTSH_RESP_OKAY);
		wr(`RTSH_FUNC_BASE + 12'h010, 32'(`RTSH_FUNC_HOLD), `RTSH_RESP_OKAY);
		for (int k = 1; k < 6; k++)
		begin
			wr(`RTSH_FREQ_BASE + 12'(4 * k), 32'(100 * k), `RTSH_RESP_OKAY);
			wr(`RTSH_ACC_BASE + 12'(4 * k), 32'h1000 + k, `RTSH_RESP_OKAY);
			wr(`RTSH_DEC_BASE + 12'(4 * k), 32'h2000 + k, `RTSH_RESP_OKAY);
		end
		step(4'h3, 20'h01003, 20'h00222, 16'd0);
		step(4'h1, 20'h00111, 20'h02003, 16'd300);
		wr(`RTSH_CTRL_OFS, 32'h3C, `RTSH_RESP_OKAY);
		step(4'h5, 20'h00111, 20'h00222, 16'd100);
		wr(`RTSH_ACC_PF_OFS, 32'd500, `RTSH_RESP_OKAY);
		wr(`RTSH_ACC_PT_OFS, 32'd3, `RTSH_RESP_OKAY);
		pause(1'b0, 16'd400, 16'd500);
		chk(32'(cnt >= 3 * T && cnt <= 3 * T + 1), 32'h1);
		wr(`RTSH_DEC_PF_OFS, 32'd200, `RTSH_RESP_OKAY);
		wr(`RTSH_DEC_PT_OFS, 32'd2, `RTSH_RESP_OKAY);
		pause(1'b1, 16'd300, 16'd200);
		chk(32'(cnt >= 2 * T && cnt <= 2 * T + 1), 32'h1);
		wr(`RTSH_ACC_PF_OFS, 32'd0, `RTSH_RESP_OKAY);
		pause(1'b0, 16'd0, 16'd0);
		chk(32'(cnt), 32'h0);
		wr(`RTSH_DEC_PF_OFS, 32'd0, `RTSH_RESP_OKAY);
		// Falling onto 0 would be a crossing if zero were a valid setting
		pause(1'b1, 16'd300, 16'd0);
		chk(32'(cnt), 32'h0);
		// Terminal hold alone, then together with an automatic hold
		@(posedge mclk_i);
		hold <= 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		chk(32'(ramp.freeze), 32'h1);
		@(posedge mclk_i);
		hold <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1;
		chk(32'(ramp.freeze), 32'h0);
		wr(`RTSH_ACC_PF_OFS, 32'd500, `RTSH_RESP_OKAY);
		wr(`RTSH_ACC_PT_OFS, 32'd1, `RTSH_RESP_OKAY);
		hold <= 1'b1;
		pause(1'b0, 16'd400, 16'd500);
		chk(32'(cnt), 32'd40);
		@(posedge mclk_i);
		hold <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1;
		chk(32'(ramp.freeze), 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
